// [core/ccst_tracker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ccst_cfg.svh"

module ccst_tracker #(
	parameter int EXEC_CYCLES = `CCST_EXEC_CYCLES,
	parameter int INIT_CYCLES = `CCST_INIT_CYCLES,
	parameter logic [3:0] APP_MAX = `CCST_APP_MAX,
	parameter logic [3:0] DEFAULT_APP = `CCST_DEFAULT_APP
) (
	// Clock and reset.
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave.
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic [31:0]                     prdata,
	// Lane state from the data path logic, same clock.
	input  wire ccst_pkg::ccst_lane_state_type lane_state,
	// Active configuration towards the data path logic.
	output ccst_pkg::ccst_lane_cfg_type [7:0] lane_path_assignment,
	output logic [7:0]                      lane_reconfig_mask,
	output logic                            lane_reconfig_pulse,
	output logic                            mgmt_init_state
);
	import ccst_pkg::*;

	if (EXEC_CYCLES < 1 || EXEC_CYCLES > 65535) begin : g_bad_exec
		$error("EXEC_CYCLES must lie between 1 and 65535");
	end
	if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
		$error("INIT_CYCLES must lie between 1 and 65535");
	end

	localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1);
	localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

	ccst_state_type s_q;
	ccst_state_type s_d;

	// Lanes whose status field currently shows the busy code.
	function automatic logic [7:0] busy_lanes(input logic [7:0][3:0] st);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			m[i] = (st[i] == `CCST_BUSY_CODE);
		end
		return m;
	endfunction

	// Checks a staged set against the triggered lanes and returns the code.
	function automatic logic [3:0] validate(
		input ccst_lane_cfg_type [7:0] st,
		input logic [7:0]              mask,
		input logic                    imm,
		input ccst_lane_state_type     ls
	);
		logic       bad_app;
		logic       bad_set;
		logic       bad_si;
		logic       in_use;
		logic       partial;
		logic [2:0] f;
		logic [3:0] a;
		logic [3:0] code;
		bad_app = 1'b0;
		bad_set = 1'b0;
		bad_si = 1'b0;
		in_use = 1'b0;
		partial = 1'b0;
		for (int i = 0; i < 8; i++) begin
			f = st[i].first_lane_index;
			a = st[i].application_select_code;
			if (mask[i]) begin
				if (a > APP_MAX) begin
					bad_app = 1'b1;
				end
				if (a != 4'h0 && (int'(f) > i
					|| st[f].application_select_code != a
					|| st[f].first_lane_index != f)) begin
					bad_set = 1'b1;
				end
				if (st[i].host_si_override && a == 4'h0) begin
					bad_si = 1'b1;
				end
				if (!imm && !ls.path_inactive_state[i]) begin
					in_use = 1'b1;
				end
				for (int j = 0; j < 8; j++) begin
					if (a != 4'h0 && !mask[j]
						&& st[j].first_lane_index == f
						&& st[j].application_select_code == a
						&& !(imm && ls.path_up_state[i])) begin
						partial = 1'b1;
					end
				end
			end
		end
		// A fixed order is used where several causes coincide.
		if (bad_app) begin
			code = `CCST_REJECT_BAD_APP;
		end else if (bad_set) begin
			code = `CCST_REJECT_BAD_SET;
		end else if (bad_si) begin
			code = `CCST_REJECT_BAD_SI;
		end else if (in_use) begin
			code = `CCST_REJECT_BUSY;
		end else if (partial) begin
			code = `CCST_REJECT_PARTIAL;
		end else begin
			code = `CCST_OK_CODE;
		end
		return code;
	endfunction

	// Register read mux; unmapped indices return zero with an error.
	function automatic logic [32:0] read_word(
		input logic [`CCST_IDX_W-1:0] idx,
		input ccst_state_type         s
	);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		case (idx)
			`CCST_IDX_STATUS_1_2: r[7:0] = {s.status[1], s.status[0]};
			`CCST_IDX_STATUS_3_4: r[7:0] = {s.status[3], s.status[2]};
			`CCST_IDX_STATUS_5_6: r[7:0] = {s.status[5], s.status[4]};
			`CCST_IDX_STATUS_7_8: r[7:0] = {s.status[7], s.status[6]};
			`CCST_IDX_STAGE0_LO: r[31:0] = s.staged[0][3:0];
			`CCST_IDX_STAGE0_HI: r[31:0] = s.staged[0][7:4];
			`CCST_IDX_STAGE1_LO: r[31:0] = s.staged[1][3:0];
			`CCST_IDX_STAGE1_HI: r[31:0] = s.staged[1][7:4];
			`CCST_IDX_APPLY0,
			`CCST_IDX_APPLY1: r[7:0] = busy_lanes(s.status);
			default: begin
				if (idx >= `CCST_IDX_ASSIGN_1 && idx <= `CCST_IDX_ASSIGN_8) begin
					r[7:0] = s.active[3'(idx - `CCST_IDX_ASSIGN_1)];
				end else begin
					r[32] = 1'b1;
				end
			end
		endcase
		return r;
	endfunction

	logic [`CCST_IDX_W-1:0] idx;
	logic [32:0]            rd;
	logic                   is_apply;
	logic [7:0]             trig;
	logic                   conflict;
	logic                   stall;
	logic                   wr_done;

	assign idx = paddr[11:2];
	assign rd = read_word(idx, s_q);
	assign is_apply = pwrite
		&& (idx == `CCST_IDX_APPLY0 || idx == `CCST_IDX_APPLY1);
	assign trig = pwdata[`CCST_APPLY_REINIT_LSB +: 8]
		| pwdata[`CCST_APPLY_NOW_LSB +: 8];
	assign conflict = |(trig & busy_lanes(s_q.status));
	// A clean apply waits in wait states while another command runs,
	// because there is only one engine and no queue.
	assign stall = is_apply && !conflict && trig != 8'h00
		&& s_q.fsm != CCST_IDLE;
	assign pready = !stall;
	assign pslverr = psel && penable && rd[32];
	assign wr_done = psel && penable && pready && pwrite && !rd[32];

	always_comb begin
		s_d = s_q;
		s_d.exec_pulse = 1'b0;
		if (psel && !penable && !pwrite) begin
			s_d.rdata = rd[31:0];
		end
		if (wr_done) begin
			case (idx)
				`CCST_IDX_STAGE0_LO: s_d.staged[0][3:0] = pwdata;
				`CCST_IDX_STAGE0_HI: s_d.staged[0][7:4] = pwdata;
				`CCST_IDX_STAGE1_LO: s_d.staged[1][3:0] = pwdata;
				`CCST_IDX_STAGE1_HI: s_d.staged[1][7:4] = pwdata;
				default: begin
				end
			endcase
		end
		case (s_q.fsm)
			CCST_INIT: begin
				for (int i = 0; i < 8; i++) begin
					s_d.active[i].application_select_code = DEFAULT_APP;
					s_d.active[i].first_lane_index = 3'h0;
					s_d.active[i].host_si_override = 1'b0;
				end
				if (s_q.cnt == INIT_LAST) begin
					s_d.cnt = 16'h0000;
					s_d.init_done = 1'b1;
					s_d.fsm = CCST_IDLE;
				end else begin
					s_d.cnt = s_q.cnt + 16'h0001;
				end
			end
			CCST_IDLE: begin
				// Refused writes fall through with no trace.
				if (wr_done && is_apply && !conflict && trig != 8'h00) begin
					for (int i = 0; i < 8; i++) begin
						if (trig[i]) begin
							s_d.status[i] = `CCST_BUSY_CODE;
						end
					end
					s_d.mask = trig;
					s_d.set = (idx == `CCST_IDX_APPLY1);
					s_d.imm = (pwdata[`CCST_APPLY_REINIT_LSB +: 8] == 8'h00);
					s_d.fsm = CCST_CHECK;
				end
			end
			CCST_CHECK: begin
				s_d.code = validate(s_q.staged[s_q.set], s_q.mask,
					s_q.imm, lane_state);
				s_d.cnt = 16'h0000;
				// Any code but success counts as a rejection and skips execution.
				if (s_d.code == `CCST_OK_CODE) begin
					s_d.fsm = CCST_RUN;
				end else begin
					s_d.fsm = CCST_REPORT;
				end
			end
			CCST_RUN: begin
				if (s_q.cnt == EXEC_LAST) begin
					for (int i = 0; i < 8; i++) begin
						if (s_q.mask[i]) begin
							s_d.active[i] = s_q.staged[s_q.set][i];
						end
					end
					s_d.exec_pulse = 1'b1;
					s_d.fsm = CCST_REPORT;
				end else begin
					s_d.cnt = s_q.cnt + 16'h0001;
				end
			end
			CCST_REPORT: begin
				for (int i = 0; i < 8; i++) begin
					if (s_q.mask[i]) begin
						s_d.status[i] = s_q.code;
					end
				end
				s_d.fsm = CCST_IDLE;
			end
			default: begin
				s_d.fsm = CCST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.fsm <= CCST_INIT;
			for (int i = 0; i < 8; i++) begin
				s_q.status[i] <= `CCST_STATUS_RESET;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign lane_path_assignment = s_q.active;
	assign lane_reconfig_mask = s_q.mask;
	assign lane_reconfig_pulse = s_q.exec_pulse;
	assign mgmt_init_state = !s_q.init_done;

endmodule // ccst_tracker

`default_nettype wire

// [core/ccst_cfg.svh]
`ifndef CCST_CFG_SVH
`define CCST_CFG_SVH

// Register indices; the byte address is four times the index.
`define CCST_IDX_W            10
`define CCST_IDX_STATUS_1_2   10'h0CA
`define CCST_IDX_STATUS_3_4   10'h0CB
`define CCST_IDX_STATUS_5_6   10'h0CC
`define CCST_IDX_STATUS_7_8   10'h0CD
`define CCST_IDX_ASSIGN_1     10'h0CE
`define CCST_IDX_ASSIGN_8     10'h0D5
`define CCST_IDX_STAGE0_LO    10'h040
`define CCST_IDX_STAGE0_HI    10'h041
`define CCST_IDX_APPLY0       10'h042
`define CCST_IDX_STAGE1_LO    10'h044
`define CCST_IDX_STAGE1_HI    10'h045
`define CCST_IDX_APPLY1       10'h046

// Apply register fields.
`define CCST_APPLY_REINIT_LSB 0
`define CCST_APPLY_NOW_LSB    8

// Status codes.
`define CCST_NO_INFO_CODE     4'h0
`define CCST_OK_CODE          4'h1
`define CCST_REJECT_GENERIC   4'h2
`define CCST_REJECT_BAD_APP   4'h3
`define CCST_REJECT_BAD_SET   4'h4
`define CCST_REJECT_BAD_SI    4'h5
`define CCST_REJECT_BUSY      4'h6
`define CCST_REJECT_PARTIAL   4'h7
`define CCST_BUSY_CODE        4'h0C

// Reset values, timing counts and the application code limit.
`define CCST_STATUS_RESET     4'h0
`define CCST_EXEC_CYCLES      16
`define CCST_INIT_CYCLES      4
`define CCST_APP_MAX          4'hF
`define CCST_DEFAULT_APP      4'h1

`endif

// [core/ccst_pkg.sv]
`default_nettype none
package ccst_pkg;

	typedef struct packed {
		logic [3:0] application_select_code;
		logic [2:0] first_lane_index;
		logic       host_si_override;
	} ccst_lane_cfg_type;

	typedef enum logic [2:0] {
		CCST_INIT,
		CCST_IDLE,
		CCST_CHECK,
		CCST_RUN,
		CCST_REPORT
	} ccst_fsm_type;

	typedef struct packed {
		logic [7:0] path_inactive_state;
		logic [7:0] path_up_state;
	} ccst_lane_state_type;

	typedef struct packed {
		ccst_fsm_type                fsm;
		logic [7:0][3:0]             status;
		ccst_lane_cfg_type [7:0]     active;
		ccst_lane_cfg_type [1:0][7:0] staged;
		logic [7:0]                  mask;
		logic                        set;
		logic                        imm;
		logic [3:0]                  code;
		logic [15:0]                 cnt;
		logic [31:0]                 rdata;
		logic                        init_done;
		logic                        exec_pulse;
	} ccst_state_type;

endpackage
`default_nettype wire

// [sim/ccst_tracker_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module ccst_tracker_asserts #(
	parameter logic [3:0] DEFAULT_APP = 4'h1
) (
	// Clock and reset.
	input wire logic                             pclk,
	input wire logic                             presetn,
	// Bus.
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pwrite,
	input wire logic [11:0]                      paddr,
	input wire logic                             pready,
	input wire logic                             pslverr,
	// Active set.
	input wire ccst_pkg::ccst_lane_cfg_type [7:0] lane_path_assignment,
	input wire logic                             lane_reconfig_pulse,
	input wire logic                             mgmt_init_state
);
	import ccst_pkg::*;
	logic cfg_bad;
	logic mapped;
	always_comb begin
		cfg_bad = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (lane_path_assignment[i][7:4] != 4'h0
					&& lane_path_assignment[i][3:1] > 3'(i))
				cfg_bad = 1'b1;
			if (lane_path_assignment[i][0]
					&& lane_path_assignment[i][7:4] == 4'h0)
				cfg_bad = 1'b1;
		end
	end
	assign mapped = paddr[11:2] inside {[10'h040:10'h042],
		[10'h044:10'h046], [10'h0CA:10'h0D5]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc; psel && penable; endsequence
	sequence s_rd_setup; psel && !penable && !pwrite; endsequence
	chk_slverr_map: assert property (s_acc |-> pslverr == !mapped)
		else $error("pslverr disagrees with the address map");
	chk_read_nowait: assert property (s_rd_setup |=> pready)
		else $error("read was stalled");
	chk_stall_bound: assert property (s_acc and !pready
			|-> ##[1:80] pready)
		else $error("apply stall did not end");
	chk_pulse_gap: assert property (lane_reconfig_pulse |=>
			!lane_reconfig_pulse [*3])
		else $error("update pulses too close");
	chk_init_quiet: assert property (mgmt_init_state
			|-> !lane_reconfig_pulse)
		else $error("update during init");
	chk_init_exit: assert property ($fell(mgmt_init_state) |->
			lane_path_assignment == {8{DEFAULT_APP, 4'h0}})
		else $error("defaults missing at end of init");
	chk_cfg_change: assert property (!$past(mgmt_init_state)
			&& $changed(lane_path_assignment) |-> lane_reconfig_pulse)
		else $error("active set changed without update");
	chk_cfg_sane: assert property (!cfg_bad)
		else $error("inconsistent active assignment");
endmodule // ccst_tracker_asserts
bind ccst_tracker ccst_tracker_asserts #(.DEFAULT_APP(DEFAULT_APP)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.lane_path_assignment(lane_path_assignment),
	.lane_reconfig_pulse(lane_reconfig_pulse),
	.mgmt_init_state(mgmt_init_state));
`default_nettype wire

// [sim/ccst_path_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ccst_path_model (
	// Clock and reset.
	input wire logic                      pclk,
	input wire logic                      presetn,
	// Lanes the bench wants running.
	input wire logic [7:0]                up_lanes,
	// Lane state towards the tracker.
	output var ccst_pkg::ccst_lane_state_type lane_state
);
	import ccst_pkg::*;
	// A lane is running or parked, never both, so validation never sees
	// a contradictory pair.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lane_state <= {8'hFF, 8'h00};
		else
			lane_state <= {~up_lanes, up_lanes};
	end
endmodule // ccst_path_model
`default_nettype wire

// [sim/test_ccst_tracker.sv]
`timescale 1ns/1ns
`default_nettype none
module test_ccst_tracker;
	import ccst_pkg::*;
	localparam logic [3:0] APP_LIM = 4'h7;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, b0;
	logic pready, pslverr, er, pulse, init;
	logic [7:0] up_lanes = '0, mask, bt, ea;
	logic [3:0] a, lc;
	ccst_lane_state_type lane_state;
	ccst_lane_cfg_type [7:0] acs;
	int fails = 0, cmp_count = 0, wt = 0;
	logic [15:0] t_lo [4] = '{16'h0101, 16'h2620, 16'h2020, 16'h2020};
	logic [7:0] t_trg [4] = '{8'h03, 8'h03, 8'h03, 8'h01};
	logic [7:0] t_up [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
	logic [7:0] t_exp [4] = '{8'h55, 8'h44, 8'h66, 8'h67};
	always #20 pclk = ~pclk;
	ccst_path_model pm (.pclk(pclk), .presetn(presetn),
		.up_lanes(up_lanes), .lane_state(lane_state));
	ccst_tracker #(.EXEC_CYCLES(4), .INIT_CYCLES(1), .APP_MAX(APP_LIM)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .lane_state(lane_state),
		.lane_path_assignment(acs), .lane_reconfig_mask(mask),
		.lane_reconfig_pulse(pulse), .mgmt_init_state(init));
	function automatic logic [3:0] f_code(input logic [3:0] x);
		return (x > APP_LIM) ? 4'h3 : 4'h1;
	endfunction
	task automatic give_verdict;
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wt = 0;
		do begin
			@(posedge pclk);
			wt++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Stage set s, fire trg, optionally fire set 1 while busy, then poll.
	task automatic cmd(input logic [9:0] s, input logic [31:0] lo, trg, x);
		apb(1'b1, 10'h040 + s, lo);
		apb(1'b1, 10'h042 + s, trg);
		if (x != 0)
			apb(1'b1, 10'h046, x);
		for (int k = 0; k < 40; k++) begin
			apb(1'b0, 10'h0CA, 0);
			if (k == 0)
				b0 = rd;
			if (rd[3:0] !== 4'hC && rd[7:4] !== 4'hC)
				break;
		end
	endtask
	initial begin
		void'($urandom(1));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("init", 0, init);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 10'h0CA + 10'(i), 0);
			chk("status", 0, rd);
		end
		apb(1'b0, 10'h0CE, 0);
		chk("assign", 32'h10, rd);
		apb(1'b1, 10'h0CA, 32'hFF);
		apb(1'b0, 10'h0CA, 0);
		chk("readonly", 0, rd);
		apb(1'b0, 10'h3FF, 0);
		chk("slverr", 1, er);
		apb(1'b1, 10'h044, 32'h0101);
		cmd(0, 32'h2020, 32'h03, 32'h03);
		chk("busy", 32'hCC, b0);
		chk("done", 32'h11, rd);
		chk("mask", 8'h03, mask);
		apb(1'b0, 10'h0CB, 0);
		chk("untouched", 0, rd);
		apb(1'b0, 10'h0CF, 0);
		chk("assign", 32'h20, rd);
		// An apply on free lanes waits in wait states until the engine idles.
		apb(1'b1, 10'h042, 32'h03);
		apb(1'b1, 10'h046, 32'h0C);
		chk("stall", 1, wt > 1);
		apb(1'b0, 10'h046, 0);
		chk("busy lanes", 32'h0C, rd);
		apb(1'b0, 10'h0CA, 0);
		chk("first done", 32'h11, rd);
		do apb(1'b0, 10'h0CB, 0); while (rd[3:0] === 4'hC);
		chk("second done", 32'h11, rd);
		apb(1'b0, 10'h044, 0);
		chk("staged", 32'h0101, rd);
		for (int i = 0; i < 4; i++) begin
			up_lanes <= t_up[i];
			cmd(0, {16'h0, t_lo[i]}, {24'h0, t_trg[i]}, 0);
			chk("reject", t_exp[i], rd[7:0]);
		end
		up_lanes <= 8'h00;
		ea = 8'h20;
		for (int i = 0; i < 6; i++) begin
			a = 4'($urandom_range(15, 1));
			bt = {a, 3'b000, 1'($urandom_range(1, 0))};
			lc = f_code(a);
			cmd(0, {16'h0, bt, bt}, 32'h03, 0);
			if (lc == 4'h1)
				ea = bt;
			chk("random", {24'h0, lc, lc}, rd);
			apb(1'b0, 10'h0CE, 0);
			chk("assign", ea, rd);
		end
		up_lanes <= 8'h03;
		cmd(0, 32'h2021, 32'h0100, 0);
		chk("partial", {24'h0, lc, 4'h1}, rd);
		apb(1'b0, 10'h0CE, 0);
		chk("host si", 32'h21, rd);
		give_verdict;
	end
	// The whole sequence needs about three hundred cycles.
	initial begin
		#400000;
		fails++;
		give_verdict;
	end
endmodule // test_ccst_tracker
`default_nettype wire
